//--- rtl/chgp_serial_port.v
// Two-wire serial slave port of the charge controller: framing, addressing,
// byte shifting, acknowledge, stretching and the register array behind it.
// Assumes the master drives the clock line and both lines have pull-ups.
//
// Notes on behaviour
// - Answer only to address 0x6b.
// - Sixty-one byte registers, indexes 0x00 to 0x3c.
// - Works at 100 and 400 kbit/s.
// - Data pin only pulled low or released.
// - Both lines high and idle means free.
// - Data falling with clock high is START.
// - Data rising with clock high is STOP.
// - Busy from START until STOP.
// - Data changes only while clock is low.
// - Bytes shift most significant bit first.
// - Ninth bit acknowledges each byte.
// - No limit on bytes per transaction.
// - Device may stretch clock after a byte.
// - Release clock once ready again.
// - Word write and word read supported.
// - Readable maker and part identifiers.
// - Transmitter releases data line during acknowledge.
// - First byte is address plus direction.
// - Index advances after each data byte.
// - Word pairs written low first, updated together.
`timescale 1ns/100ps
`include "chgp_defines.vh"

module chgp_serial_port #(
	parameter [7:0] MAKER_ID    = 8'h5a, // Arbitrary value.
	parameter [7:0] PART_ID     = 8'ha5, // Arbitrary value.
	parameter       STRETCH_CYC = 4      // One less than the core cycles the clock is held after a byte.
)(
	// Clock and reset.
	input  wire       mclk,
	input  wire       nrst,
	// Serial clock pin, split into its three signals.
	input  wire       scl_in,
	output reg        scl_out_q,
	output reg        scl_oe_q,
	// Serial data pin, split into its three signals.
	input  wire       sda_in,
	output reg        sda_out_q,
	output reg        sda_oe_q,
	// Device status byte shown in the first read-only register.
	input  wire [7:0] status_byte,
	// Bus busy indication for the rest of the device.
	output reg        bus_busy_q
);

	// Protocol states.
	localparam [2:0] ST_IDLE  = 3'h0; // Waiting for START.
	localparam [2:0] ST_ADDR  = 3'h1; // Receiving address byte.
	localparam [2:0] ST_ACK   = 3'h2; // Device drives acknowledge.
	localparam [2:0] ST_RXB   = 3'h3; // Receiving index or data byte.
	localparam [2:0] ST_TXB   = 3'h4; // Sending a data byte.
	localparam [2:0] ST_MACK  = 3'h5; // Master acknowledges a sent byte.
	localparam [2:0] ST_SKIP  = 3'h6; // Not addressed, or master ended a read; wait for STOP or START.

	wire       scl_f;       // Filtered clock line.
	wire       sda_f;       // Filtered data line.
	reg        scl_prev_q;  // Clock line one cycle ago.
	reg        sda_prev_q;  // Data line one cycle ago.
	reg  [2:0] state_q;     // Protocol state.
	reg  [3:0] bit_cnt_q;   // Bits shifted within the current byte.
	reg  [7:0] shift_q;     // Shift register for both directions.
	reg        read_q;      // Direction of the current transaction.
	reg        have_idx_q;  // Register index already received.
	reg        was_addr_q;  // Byte being acknowledged is the address.
	reg  [5:0] idx_q;       // Current register index.
	reg        wr_en_q;     // One-cycle write strobe to the array.
	reg  [7:0] wr_data_q;   // Byte being written.
	reg  [5:0] wr_idx_q;    // Index being written.
	reg  [3:0] stretch_q;   // Remaining stretch cycles.
	wire [7:0] rd_data;     // Byte at the current index.

	// Clean edges of the two lines.
	wire scl_rise = scl_f & ~scl_prev_q;
	wire scl_fall = ~scl_f & scl_prev_q;
	wire start_c  = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	wire stop_c   = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

	// Both lines pass the same synchroniser and filter.
	chgp_pin_filter u_scl_filt (
		.mclk    (mclk),
		.nrst    (nrst),
		.pin_in  (scl_in),
		.level_q (scl_f)
	);

	chgp_pin_filter u_sda_filt (
		.mclk    (mclk),
		.nrst    (nrst),
		.pin_in  (sda_in),
		.level_q (sda_f)
	);

	// Register array behind the port.
	chgp_reg_file #(
		.MAKER_ID (MAKER_ID),
		.PART_ID  (PART_ID)
	) u_regs (
		.mclk        (mclk),
		.nrst        (nrst),
		.wr_en       (wr_en_q),
		.wr_idx      (wr_idx_q),
		.wr_data     (wr_data_q),
		.rd_idx      (idx_q),
		.rd_data     (rd_data),
		.status_byte (status_byte)
	);

	// Main protocol engine. Everything is decided on filtered edges of the
	// lines, which keeps the engine correct at both bit rates since one bit
	// lasts hundreds of core cycles even in fast mode.
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			state_q    <= ST_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			read_q     <= 1'b0;
			have_idx_q <= 1'b0;
			was_addr_q <= 1'b0;
			idx_q      <= 6'h00;
			wr_en_q    <= 1'b0;
			wr_data_q  <= 8'h00;
			wr_idx_q   <= 6'h00;
			stretch_q  <= 4'h0;
			scl_out_q  <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_out_q  <= 1'b0;
			sda_oe_q   <= 1'b0;
			bus_busy_q <= 1'b0;
		end
		else
		begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
			wr_en_q    <= 1'b0;
			// Pins are only ever pulled low, never driven high.
			scl_out_q  <= 1'b0;
			sda_out_q  <= 1'b0;

			// Release the clock line once the stretch has run out.
			if (stretch_q != 4'h0)
				stretch_q <= stretch_q - 4'h1;
			else
				scl_oe_q <= 1'b0;

			if (start_c)
			begin
				// A START, first or repeated, always begins an address byte.
				state_q    <= ST_ADDR;
				bus_busy_q <= 1'b1;
				bit_cnt_q  <= 4'h0;
				have_idx_q <= 1'b0;
				sda_oe_q   <= 1'b0;
				scl_oe_q   <= 1'b0;
				stretch_q  <= 4'h0;
			end
			else if (stop_c)
			begin
				// STOP frees the bus, returns to idle and lets go of both lines.
				state_q    <= ST_IDLE;
				bus_busy_q <= 1'b0;
				sda_oe_q   <= 1'b0;
				scl_oe_q   <= 1'b0;
				stretch_q  <= 4'h0;
			end
			else
			begin
				case (state_q)
				ST_ADDR, ST_RXB:
				begin
					// Sample on rising clock, MSB first.
					if (scl_rise)
					begin
						shift_q   <= {shift_q[6:0], sda_f};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (scl_fall && bit_cnt_q == `CHGP_BYTE_BITS)
					begin
						bit_cnt_q <= 4'h0;
						if (state_q == ST_ADDR)
						begin
							if (shift_q[7:1] == `CHGP_SLAVE_ADDR)
							begin
								read_q     <= shift_q[0];
								was_addr_q <= 1'b1;
								sda_oe_q   <= 1'b1;
								state_q    <= ST_ACK;
							end
							else
								state_q <= ST_SKIP;
						end
						else
						begin
							was_addr_q <= 1'b0;
							sda_oe_q   <= 1'b1;
							state_q    <= ST_ACK;
							if (!have_idx_q)
							begin
								// First byte after the address is the index.
								idx_q      <= shift_q[5:0];
								have_idx_q <= 1'b1;
							end
							else
							begin
								// Store and step to the next register.
								wr_en_q   <= 1'b1;
								wr_idx_q  <= idx_q;
								wr_data_q <= shift_q;
								idx_q     <= idx_q + 6'h1;
							end
						end
						// Hold the clock low briefly while the byte is handled, but only
						// for a byte we acknowledge: a stranger's transfer is never slowed.
						if (state_q == ST_RXB || shift_q[7:1] == `CHGP_SLAVE_ADDR)
						begin
							scl_oe_q  <= 1'b1;
							stretch_q <= STRETCH_CYC[3:0];
						end
					end
				end
				ST_ACK:
				begin
					// Acknowledge bit ends on the falling clock.
					if (scl_fall)
					begin
						if (was_addr_q && read_q)
						begin
							// Load the first byte for the master to read.
							shift_q  <= rd_data;
							sda_oe_q <= ~rd_data[7];
							state_q  <= ST_TXB;
						end
						else
						begin
							sda_oe_q <= 1'b0;
							state_q  <= ST_RXB;
						end
					end
				end
				ST_TXB:
				begin
					// Count bits on rising edges, change data on falling ones.
					if (scl_rise)
						bit_cnt_q <= bit_cnt_q + 4'h1;
					else if (scl_fall)
					begin
						if (bit_cnt_q == `CHGP_BYTE_BITS)
						begin
							// Release data for the master's acknowledge.
							sda_oe_q  <= 1'b0;
							bit_cnt_q <= 4'h0;
							idx_q     <= idx_q + 6'h1;
							state_q   <= ST_MACK;
						end
						else
						begin
							shift_q  <= {shift_q[6:0], 1'b0};
							sda_oe_q <= ~shift_q[6];
						end
					end
				end
				ST_MACK:
				begin
					// Sample the master's answer; low means send another.
					if (scl_rise)
						shift_q[0] <= sda_f;
					else if (scl_fall)
					begin
						if (!shift_q[0])
						begin
							shift_q  <= rd_data;
							sda_oe_q <= ~rd_data[7];
							state_q  <= ST_TXB;
						end
						else
							state_q <= ST_SKIP;
					end
				end
				ST_SKIP:
				begin
					// Stay off the bus until a new START or a STOP.
					sda_oe_q <= 1'b0;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule // chgp_serial_port

//--- shared/chgp_defines.vh
// Constants for the charger serial slave port: bus address, register space,
// identifier locations, word-pair indexes and pin filter timing.
// Assumes a 100 MHz core clock.
`ifndef CHGP_DEFINES_VH
`define CHGP_DEFINES_VH

// Fixed 7-bit slave address.
`define CHGP_SLAVE_ADDR     7'h6b
// Highest register index; the space runs from index zero up to this one.
`define CHGP_REG_LAST       6'h3c
// Number of register slots held in the array.
`define CHGP_REG_COUNT      61
// Index of the read-only maker identifier.
`define CHGP_MAKER_IDX      6'h2e
// Index of the read-only part identifier.
`define CHGP_PART_IDX       6'h2f
// Reset value of every writable register.
`define CHGP_REG_RESET      8'h00
// Low-byte indexes of the two-byte values that update as a pair.
`define CHGP_PAIR_CHG_CUR   6'h02
`define CHGP_PAIR_MAX_VOLT  6'h04
`define CHGP_PAIR_OTG_VOLT  6'h06
`define CHGP_PAIR_IN_VOLT   6'h0a
`define CHGP_PAIR_IIN_DPM   6'h24
// First index of the read-only status block, and its last.
`define CHGP_RO_FIRST       6'h20
`define CHGP_RO_LAST        6'h2f
// Glitch filter: a pin level must hold this long before it is believed.
`define CHGP_FILT_NS        50
`define CHGP_CLK_MHZ        100
`define CHGP_FILT_CYC       ((`CHGP_FILT_NS * `CHGP_CLK_MHZ + 999) / 1000)
// Bits in a byte.
`define CHGP_BYTE_BITS      4'h8

`endif

//--- rtl/chgp_pin_filter.v
// Two-flop synchroniser followed by a hold-time glitch filter for one bus line.
// Assumes the pin is asynchronous to mclk and rests high when released.
`timescale 1ns/100ps
`include "chgp_defines.vh"

module chgp_pin_filter #(
	parameter FILT_CYC = `CHGP_FILT_CYC
)(
	// Clock and reset.
	input  wire mclk,
	input  wire nrst,
	// Raw pin level.
	input  wire pin_in,
	// Filtered level.
	output reg  level_q
);

	reg       sync1_q;  // First synchroniser stage, read only by the second.
	reg       sync2_q;  // Second synchroniser stage.
	reg [3:0] cnt_q;    // Cycles the synchronised level has differed.

	// Synchronise, then accept a new level only once it has held long enough.
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			cnt_q   <= 4'h0;
			level_q <= 1'b1;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			if (sync2_q == level_q)
				cnt_q <= 4'h0;
			else if (cnt_q == FILT_CYC[3:0] - 4'h1)
			begin
				// Level has settled; pass it on.
				level_q <= sync2_q;
				cnt_q   <= 4'h0;
			end
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end

endmodule // chgp_pin_filter

//--- rtl/chgp_reg_file.v
// Byte-wide register array with read-only identifiers and a status block.
// Assumes the protocol engine gives one write strobe per received data byte.
`timescale 1ns/100ps
`include "chgp_defines.vh"

module chgp_reg_file #(
	parameter [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
	parameter [7:0] PART_ID  = 8'ha5  // Arbitrary value.
)(
	// Clock and reset.
	input  wire       mclk,
	input  wire       nrst,
	// Write side.
	input  wire       wr_en,
	input  wire [5:0] wr_idx,
	input  wire [7:0] wr_data,
	// Read side.
	input  wire [5:0] rd_idx,
	output wire [7:0] rd_data,
	// Status inputs from the rest of the device for the read-only block.
	input  wire [7:0] status_byte
);

	reg [7:0] mem_q [0:`CHGP_REG_COUNT-1]; // Register storage.
	reg [7:0] pair_lo_q;                   // Held low byte of a pair.
	reg [5:0] pair_idx_q;                  // Index of the held low byte.
	reg       pair_ok_q;                   // A low byte waits for its high byte.
	integer   i;

	// Low-byte index of a two-byte value, or not.
	function is_pair_lo;
		input [5:0] idx;
		begin
			is_pair_lo = (idx == `CHGP_PAIR_CHG_CUR) || (idx == `CHGP_PAIR_MAX_VOLT) ||
				(idx == `CHGP_PAIR_OTG_VOLT) || (idx == `CHGP_PAIR_IN_VOLT) ||
				(idx == `CHGP_PAIR_IIN_DPM);
		end
	endfunction

	// Writable unless outside the space or within the read-only block.
	function is_writable;
		input [5:0] idx;
		begin
			is_writable = (idx <= `CHGP_REG_LAST) &&
				!((idx >= `CHGP_RO_FIRST) && (idx <= `CHGP_RO_LAST));
		end
	endfunction

	// Stores writes; two-byte values land together on the high byte.
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			for (i = 0; i < `CHGP_REG_COUNT; i = i + 1)
				mem_q[i] <= `CHGP_REG_RESET;
			pair_lo_q  <= 8'h00;
			pair_idx_q <= 6'h00;
			pair_ok_q  <= 1'b0;
		end
		else if (wr_en)
		begin
			if (is_pair_lo(wr_idx))
			begin
				// Hold the low byte until the matching high byte comes.
				pair_lo_q  <= wr_data;
				pair_idx_q <= wr_idx;
				pair_ok_q  <= 1'b1;
			end
			else if (is_pair_lo(wr_idx - 6'h1))
			begin
				// High byte: commit only straight after its own low byte.
				if (pair_ok_q && pair_idx_q == wr_idx - 6'h1 && is_writable(wr_idx))
				begin
					mem_q[pair_idx_q] <= pair_lo_q;
					mem_q[wr_idx]     <= wr_data;
				end
				pair_ok_q <= 1'b0;
			end
			else
			begin
				pair_ok_q <= 1'b0;
				if (is_writable(wr_idx))
					mem_q[wr_idx] <= wr_data;
			end
		end
	end

	// Identifiers are constants; the status byte at index 0x20 comes from the device; unmapped reads zero.
	assign rd_data = (rd_idx == `CHGP_MAKER_IDX) ? MAKER_ID :
		(rd_idx == `CHGP_PART_IDX) ? PART_ID :
		(rd_idx == `CHGP_RO_FIRST) ? status_byte :
		(rd_idx > `CHGP_REG_LAST) ? 8'h00 : mem_q[rd_idx];

endmodule // chgp_reg_file

//--- tb/chgp_port_monitor.sv
// Checker for the serial slave port; sees only the top module's pins.
// Assumes one mclk domain with a synchronous active-low reset.
`timescale 1ns/100ps
module chgp_port_monitor #(
	parameter STRETCH_CYC = 4 // One less than the core cycles of clock hold after a byte.
)(
	// Clock and reset.
	input wire logic       mclk,
	input wire logic       nrst,
	// Pins.
	input wire logic       scl_in,
	input wire logic       scl_out_q,
	input wire logic       scl_oe_q,
	input wire logic       sda_in,
	input wire logic       sda_out_q,
	input wire logic       sda_oe_q,
	// Status and busy.
	input wire logic [7:0] status_byte,
	input wire logic       bus_busy_q
);
	// Length of the current clock hold, in core cycles.
	logic [7:0] hold_q;
	// Counts while the port holds the clock; a runaway hold shows here.
	always @(posedge mclk)
	begin
		if (!nrst || !scl_oe_q)
			hold_q <= 8'h00;
		else
			hold_q <= hold_q + 8'h01;
	end
	default clocking mon_cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Data falls while the clock rests high.
	sequence start_seq;
		$fell(sda_in) && scl_in && $past(scl_in);
	endsequence
	// Data rises under a high clock, not because the port let go.
	sequence stop_seq;
		$rose(sda_in) && !$past(sda_oe_q) && scl_in && $past(scl_in);
	endsequence
	sda_low_only_a: assert property (sda_out_q == 1'b0)
		else $error("data pin driven high");
	scl_low_only_a: assert property (scl_out_q == 1'b0)
		else $error("clock pin driven high");
	idle_quiet_a: assert property (!bus_busy_q |-> !sda_oe_q && !scl_oe_q)
		else $error("pins pulled on a free bus");
	start_busy_a: assert property (start_seq |-> ##[1:16] bus_busy_q)
		else $error("start not seen");
	stop_free_a: assert property (stop_seq |-> ##[1:16] !bus_busy_q)
		else $error("stop not seen");
	free_on_stop_a: assert property ($fell(bus_busy_q) |-> sda_in && scl_in)
		else $error("bus freed without stop");
	ack_release_a: assert property ($rose(sda_oe_q) |-> ##[1:300] !sda_oe_q)
		else $error("data line never released");
	stretch_len_a: assert property ($fell(scl_oe_q) |-> hold_q == STRETCH_CYC + 1)
		else $error("clock hold length wrong");
	stretch_cap_a: assert property (hold_q <= STRETCH_CYC + 1)
		else $error("clock held too long");
	stretch_ack_a: assert property ($rose(scl_oe_q) |-> sda_oe_q)
		else $error("clock held without acknowledge");
endmodule // chgp_port_monitor

//--- tb/chgp_mst.sv
// Behavioural bus master for the serial slave port bench.
// Assumes the bench resolves both pins with pull-ups from all enables.
`timescale 1ns/100ps
module chgp_mst (
	// Core clock that paces every pin change.
	input  wire logic mclk,
	// Resolved pin levels.
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Master side of each pin; a 1 releases the line.
	output logic      scl_m,
	output logic      sda_m,
	// High when a held clock never came back.
	output logic      stuck
);
	// Both lines rest released; the clock only runs inside frames.
	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		stuck = 1'b0;
	end
	// Waits a number of core cycles.
	task tick(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	// One clock pulse per bit; data moves only while the clock is low.
	task bit_io(input logic b, output logic s);
		integer k;
		begin
			sda_m <= b;
			tick(4);
			scl_m <= 1'b1;
			k = 0;
			tick(1);
			// The slave may hold the clock; wait, but not forever.
			while (scl_in !== 1'b1 && k < 400)
			begin
				k = k + 1;
				tick(1);
			end
			stuck <= (k >= 400);
			tick(2);
			s = sda_in;
			tick(3);
			scl_m <= 1'b0;
			// Low for ten cycles and high for six: a 160 ns bit period.
			tick(6);
		end
	endtask
	// Start or repeated start, only the master makes these.
	task start();
		sda_m <= 1'b1;
		tick(4);
		scl_m <= 1'b1;
		tick(8);
		sda_m <= 1'b0;
		tick(8);
		scl_m <= 1'b0;
		tick(8);
	endtask
	// Stop ends every frame and frees the bus.
	task stop();
		sda_m <= 1'b0;
		tick(4);
		scl_m <= 1'b1;
		tick(8);
		sda_m <= 1'b1;
		tick(16);
	endtask
	// Sends a byte, first bit most significant; returns the acknowledge.
	task tx(input logic [7:0] d, output logic ack);
		logic s;
		begin
			for (int i = 7; i >= 0; i--)
				bit_io(d[i], s);
			bit_io(1'b1, s);
			ack = !s;
		end
	endtask
	// Receives a byte and answers it.
	task rx(output logic [7:0] d, input logic ack);
		logic s;
		begin
			for (int i = 7; i >= 0; i--)
				bit_io(1'b1, d[i]);
			bit_io(!ack, s);
		end
	endtask
endmodule // chgp_mst

//--- tb/chgp_serial_port_tb_top.sv
// Self-checking bench for the serial slave port with a behavioural master.
// Assumes the design files and their header are on the include path.
`timescale 1ns/100ps
module chgp_serial_port_tb_top;
	logic       mclk = 1'b0;
	logic       nrst;
	logic [7:0] status_byte;
	logic [7:0] r0, r1;
	wire        scl_out_q, scl_oe_q, sda_out_q, sda_oe_q, bus_busy_q;
	wire        scl_m, sda_m, stuck;
	// Open-drain pins with pull-ups: low while any party pulls low.
	wire        scl_in = scl_m & ~(scl_oe_q & ~scl_out_q);
	wire        sda_in = sda_m & ~(sda_oe_q & ~sda_out_q);
	integer     err_count = 0;
	integer     num_checks = 0;
	always #5 mclk = ~mclk;
	chgp_serial_port #(.STRETCH_CYC(4)) i_chgp_serial_port (.mclk(mclk), .nrst(nrst),
		.scl_in(scl_in), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_in(sda_in),
		.sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .status_byte(status_byte),
		.bus_busy_q(bus_busy_q));
	chgp_mst i_chgp_mst (.mclk(mclk), .scl_in(scl_in), .sda_in(sda_in), .scl_m(scl_m),
		.sda_m(sda_m), .stuck(stuck));
	// A clock that stays held cuts the run short.
	always @(posedge mclk)
	begin
		if (stuck === 1'b1)
		begin
			err_count = err_count + 1;
			$display("MISMATCH t=%0t clock held low", $time);
			final_report();
		end
	end
	task final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	// Writes one or two bytes from a register index.
	task wr(input logic [7:0] idx, d0, d1, input integer n);
		logic a;
		begin
			i_chgp_mst.start();
			i_chgp_mst.tx(8'hd6, a);
			chk8({7'h00, a}, 8'h01);
			i_chgp_mst.tx(idx, a);
			i_chgp_mst.tx(d0, a);
			if (n > 1)
				i_chgp_mst.tx(d1, a);
			chk8({7'h00, a}, 8'h01);
			i_chgp_mst.stop();
		end
	endtask
	// Reads two bytes into r0 and r1 through a repeated start.
	task rd(input logic [7:0] idx);
		logic a;
		begin
			i_chgp_mst.start();
			i_chgp_mst.tx(8'hd6, a);
			i_chgp_mst.tx(idx, a);
			i_chgp_mst.start();
			i_chgp_mst.tx(8'hd7, a);
			chk8({7'h00, a}, 8'h01);
			i_chgp_mst.rx(r0, 1'b1);
			i_chgp_mst.rx(r1, 1'b0);
			i_chgp_mst.stop();
		end
	endtask
	task t_multi();
		wr(8'h0c, 8'h3c, 8'ha5, 2);
		rd(8'h0c);
		chk8(r0, 8'h3c);
		chk8(r1, 8'ha5);
	endtask
	// A neighbour's address gets no answer.
	task t_addr();
		logic a;
		begin
			i_chgp_mst.start();
			i_chgp_mst.tx(8'hd4, a);
			chk8({7'h00, a}, 8'h00);
			chk8({7'h00, bus_busy_q}, 8'h01);
			i_chgp_mst.stop();
			chk8({7'h00, bus_busy_q}, 8'h00);
		end
	endtask
	task t_ident();
		rd(8'h2e);
		chk8(r0, 8'h5a);
		chk8(r1, 8'ha5);
	endtask
	// Status is shown, and a write to it is dropped.
	task t_status();
		@(posedge mclk);
		status_byte <= 8'h96;
		wr(8'h20, 8'h55, 8'h00, 1);
		rd(8'h20);
		chk8(r0, 8'h96);
	endtask
	// A lone low byte of a pair is dropped; a full pair lands.
	task t_pair();
		wr(8'h02, 8'h11, 8'h00, 1);
		rd(8'h02);
		chk8(r0, 8'h00);
		wr(8'h02, 8'h11, 8'h22, 2);
		rd(8'h02);
		chk8(r0, 8'h11);
		chk8(r1, 8'h22);
	endtask
	// Last register holds data; the index past it is empty.
	task t_edge();
		wr(8'h3c, 8'h77, 8'h55, 2);
		rd(8'h3c);
		chk8(r0, 8'h77);
		chk8(r1, 8'h00);
	endtask
	initial
	begin
		nrst = 1'b0;
		status_byte = 8'h00;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		repeat (12) @(posedge mclk);
		t_multi();
		t_addr();
		t_ident();
		t_status();
		t_pair();
		t_edge();
		final_report();
	end
endmodule // chgp_serial_port_tb_top
bind chgp_serial_port chgp_port_monitor #(.STRETCH_CYC(STRETCH_CYC)) i_chgp_port_monitor (
	.mclk(mclk), .nrst(nrst), .scl_in(scl_in), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q),
	.sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
	.status_byte(status_byte), .bus_busy_q(bus_busy_q));
